// *** qbp_pins_model.sv ***
// outside circuitry on the forty port pins
`timescale 1ns/10ps
module qbp_pins_model (
   input  wire logic        clk_i,
   input  wire logic [39:0] pull_down_i,
   input  wire logic [39:0] pullup_i,
   input  wire logic [39:0] ext_low_i,
   output logic      [39:0] pin_o
);
   logic [39:0] float_q = 40'h0;
   // an undriven pin toggles so no guessed level can pass for a real one
   always @(posedge clk_i) float_q <= ~float_q;
   assign pin_o = ~pull_down_i & ~ext_low_i & (pullup_i | float_q);
endmodule

// *** qbp_pkg.sv ***
// package for the quasi-bidirectional port control block
package qbp_pkg;
   localparam int    NUM_PORTS      = 5;
   localparam int    PORT_W         = 8;
   localparam int    NUM_QB         = 4;
   localparam [7:0]  PORT0_ADDR     = 8'h80;
   localparam [7:0]  PORT1_ADDR     = 8'h90;
   localparam [7:0]  PORT2_ADDR     = 8'ha0;
   localparam [7:0]  PORT3_ADDR     = 8'hb0;
   localparam [7:0]  PORT4_ADDR     = 8'hc0;
   localparam [7:0]  LATCH_RESET    = 8'hff;
   localparam int    BOOST_OSC_PER  = 2;
   localparam int    OSC_PERIOD_NS  = 8;
   localparam int    BOOST_CYCLES   = BOOST_OSC_PER;
   localparam [1:0]  BOOST_CNT_LOAD = 2'(BOOST_CYCLES);

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       rmw;
      logic [7:0] addr;
      logic [7:0] wdata;
   } qbp_sfr_req_t;

   typedef enum logic [0:0] {
      QBP_IDLE    = 1'b0,
      QBP_PENDING = 1'b1
   } qbp_rmw_state_t;
endpackage

// *** qbp_port_ctrl.sv ***
// latches, boost pulse and pin drive control for the five i/o ports
//
// Operation
// - reset sets every bit of every port latch to one.
// - writing one after zero releases pin to input, pull-down off.
// - read-modify-write latch update happens at the end of the instruction.
// - pins follow the read-modify-write result early in the next instruction.
// - ports 1-4 zero-to-one latch change fires boost pull-up for 2 clocks.
// - ports 1-4 weak hold pull-up on while pin reads one.
// - ports 1-4 very weak pull-up on whenever the bit's drive level (latch gated by alternate output or bus) is one.
// - ports 1-4 quasi-bidirectional: latch one reads high, externally pullable low.
// - port 0 has no pull-up outside bus cycles; latch one leaves pin floating.
// - port 2 boost pull-up also assists ones during external bus cycles.
// - read-modify-write reads return latch value, not pin level.
// - ports 1,3,4 with latch one: alternate output sets driven level.
// - external memory cycles drive ports 0 and 2 from address/data lines.
`timescale 1ns/10ps
module qbp_port_ctrl (
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_i,
   input  wire qbp_pkg::qbp_sfr_req_t sfr_req_i,
   input  wire logic                 instr_end_i,
   input  wire logic                 instr_start_i,
   input  wire logic                 ext_bus_i,
   input  wire logic [7:0]           ext_p0_data_i,
   input  wire logic [7:0]           ext_p2_addr_i,
   input  wire logic [7:0]           alt_out_p1_i,
   input  wire logic [7:0]           alt_out_p3_i,
   input  wire logic [7:0]           alt_out_p4_i,
   input  wire logic [39:0]          pin_i,
   output logic      [7:0]           sfr_rdata_o,
   output logic      [39:0]          pull_down_o,
   output logic      [39:0]          boost_pullup_o,
   output logic      [39:0]          weak_hold_pullup_o,
   output logic      [39:0]          very_weak_pullup_o,
   output logic      [39:0]          latch_o
);
   localparam int N = qbp_pkg::NUM_PORTS;
   localparam int W = qbp_pkg::PORT_W;

   logic [W-1:0]   latch_q [N];
   logic [W-1:0]   drive_q [N];
   logic [W-1:0]   rmw_val_q;
   logic [2:0]     rmw_port_q;
   logic           pin_upd_q;
   qbp_pkg::qbp_rmw_state_t rmw_state_q;
   // one counter per pin so ports switch independently
   logic [1:0]     boost_cnt_q [N][W];

   // address decode shared by write, read and pending update
   function automatic logic [2:0] port_sel(input logic [7:0] a);
      if (a == qbp_pkg::PORT0_ADDR) begin
         port_sel = 3'd0;
      end else if (a == qbp_pkg::PORT1_ADDR) begin
         port_sel = 3'd1;
      end else if (a == qbp_pkg::PORT2_ADDR) begin
         port_sel = 3'd2;
      end else if (a == qbp_pkg::PORT3_ADDR) begin
         port_sel = 3'd3;
      end else if (a == qbp_pkg::PORT4_ADDR) begin
         port_sel = 3'd4;
      end else begin
         port_sel = 3'd7;
      end
   endfunction

   // rising drive level starts a boost; port 0 only while the bus owns it
   function automatic logic boost_fire(input logic lvl, input logic lvl_q, input logic gate);
      boost_fire = lvl && !lvl_q && gate;
   endfunction

   logic [2:0] sel;
   assign sel = port_sel(sfr_req_i.addr);

   // rmw write is held until instruction end
   // a newer rmw write replaces one still pending
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rmw_state_q <= qbp_pkg::QBP_IDLE;
         rmw_val_q   <= 8'h00;
         rmw_port_q  <= 3'd7;
      end else if (sfr_req_i.wr && sfr_req_i.rmw && sel != 3'd7) begin
         rmw_state_q <= qbp_pkg::QBP_PENDING;
         rmw_val_q   <= sfr_req_i.wdata;
         rmw_port_q  <= sel;
      end else if (rmw_state_q == qbp_pkg::QBP_PENDING && instr_end_i) begin
         rmw_state_q <= qbp_pkg::QBP_IDLE;
      end
   end

   // latches: plain writes at once, rmw writes at instruction end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int p = 0; p < N; p++) begin
            latch_q[p] <= qbp_pkg::LATCH_RESET;
         end
      end else begin
         if (rmw_state_q == qbp_pkg::QBP_PENDING && instr_end_i && rmw_port_q < 3'd5) begin
            latch_q[rmw_port_q] <= rmw_val_q;
         end
         if (sfr_req_i.wr && !sfr_req_i.rmw && sel != 3'd7) begin
            latch_q[sel] <= sfr_req_i.wdata;
         end
      end
   end

   // drive copy lags rmw changes until next instruction starts
   // plain writes reach the pins at once unless an rmw result is waiting; then every port waits for instruction start
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_upd_q <= 1'b0;
         for (int p = 0; p < N; p++) begin
            drive_q[p] <= qbp_pkg::LATCH_RESET;
         end
      end else begin
         if (rmw_state_q == qbp_pkg::QBP_PENDING && instr_end_i) begin
            pin_upd_q <= 1'b1;
         end else if (instr_start_i) begin
            pin_upd_q <= 1'b0;
         end
         for (int p = 0; p < N; p++) begin
            if (!pin_upd_q || instr_start_i) begin
               drive_q[p] <= latch_q[p];
            end
         end
      end
   end

   // read returns latch contents for rmw, pin level otherwise
   // latch read keeps a loaded pin from reading back as zero
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_req_i.rd && sel < 3'd5) begin
         if (sfr_req_i.rmw) begin
            sfr_rdata_o <= latch_q[sel];
         end else begin
            sfr_rdata_o <= pin_i[sel*W +: W];
         end
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

   // effective drive level per bit
   logic [W-1:0] level [N];
   logic         bus_on;
   always_comb begin
      // bus owns ports 0 and 2 for the length of an external cycle
      bus_on   = ext_bus_i;
      level[0] = bus_on ? ext_p0_data_i : drive_q[0];
      // alternate output can only pull low while its latch bit is one
      level[1] = drive_q[1] & alt_out_p1_i;
      level[2] = bus_on ? ext_p2_addr_i : drive_q[2];
      level[3] = drive_q[3] & alt_out_p3_i;
      level[4] = drive_q[4] & alt_out_p4_i;
   end

   logic [W-1:0] level_q [N];
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int p = 0; p < N; p++) begin
            level_q[p] <= qbp_pkg::LATCH_RESET;
         end
      end else begin
         for (int p = 0; p < N; p++) begin
            level_q[p] <= level[p];
         end
      end
   end

   // boost pulse counter per bit, ports 1-4 (port 0 only on bus cycles)
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int p = 0; p < N; p++) begin
            for (int b = 0; b < W; b++) begin
               boost_cnt_q[p][b] <= 2'd0;
            end
         end
      end else begin
         for (int p = 0; p < N; p++) begin
            for (int b = 0; b < W; b++) begin
               if (boost_fire(level[p][b], level_q[p][b], p != 0 || bus_on)) begin
                  boost_cnt_q[p][b] <= qbp_pkg::BOOST_CNT_LOAD;
               end else if (boost_cnt_q[p][b] != 2'd0) begin
                  boost_cnt_q[p][b] <= boost_cnt_q[p][b] - 2'd1;
               end
            end
         end
      end
   end

   // pin control outputs, registered
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pull_down_o        <= '0;
         boost_pullup_o     <= '0;
         weak_hold_pullup_o <= '0;
         very_weak_pullup_o <= '0;
         latch_o            <= {N{qbp_pkg::LATCH_RESET}};
      end else begin
         for (int p = 0; p < N; p++) begin
            latch_o[p*W +: W] <= latch_q[p];
            for (int b = 0; b < W; b++) begin
               pull_down_o[p*W+b] <= !level[p][b];
               boost_pullup_o[p*W+b] <= boost_fire(level[p][b], level_q[p][b],
                                                   p != 0 || bus_on) ||
                                        boost_cnt_q[p][b] > 2'd1;
               // port 0 stays open-drain outside bus cycles
               if (p == 0) begin
                  weak_hold_pullup_o[b] <= 1'b0;
                  very_weak_pullup_o[b] <= 1'b0;
               end else begin
                  // follows the pin, so an outside low also drops the hold
                  weak_hold_pullup_o[p*W+b] <= pin_i[p*W+b];
                  very_weak_pullup_o[p*W+b] <= level[p][b];
               end
            end
         end
      end
   end
endmodule

// *** qbp_port_ctrl_checker.sv ***
// assertions on the port control outputs
`timescale 1ns/10ps
module qbp_port_ctrl_checker (
   input wire logic                  clk_sys_i,
   input wire logic                  rst_i,
   input wire qbp_pkg::qbp_sfr_req_t sfr_req_i,
   input wire logic                  ext_bus_i,
   input wire logic [7:0]            ext_p0_data_i,
   input wire logic [7:0]            ext_p2_addr_i,
   input wire logic [39:0]           pin_i,
   input wire logic [7:0]            sfr_rdata_o,
   input wire logic [39:0]           pull_down_o,
   input wire logic [39:0]           boost_pullup_o,
   input wire logic [39:0]           weak_hold_pullup_o,
   input wire logic [39:0]           very_weak_pullup_o,
   input wire logic [39:0]           latch_o
);
   wire logic rmw_rd = sfr_req_i.rd & sfr_req_i.rmw & (sfr_req_i.addr == 8'h90);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_reset_latch_ones: assert property ($past(rst_i) |-> latch_o == '1)
      else $error("latch not all ones after reset");
   a_weak_hold_pin: assert property (!$past(rst_i) |->
      weak_hold_pullup_o[39:8] == $past(pin_i[39:8])) else $error("hold pull-up off pin");
   a_very_weak_off: assert property (!$past(rst_i) |->
      very_weak_pullup_o[39:8] == ~pull_down_o[39:8]) else $error("very weak pull-up wrong");
   a_port0_no_pull: assert property (weak_hold_pullup_o[7:0] == 8'h00 &&
      very_weak_pullup_o[7:0] == 8'h00) else $error("port 0 has a pull-up");
   a_port0_no_boost: assert property (!$past(ext_bus_i) && !$past(ext_bus_i, 2) |->
      boost_pullup_o[7:0] == 8'h00) else $error("port 0 boost outside bus cycle");
   a_ext_p0_drive: assert property ((ext_bus_i && $stable(ext_p0_data_i)) [*4] |->
      pull_down_o[7:0] == ~ext_p0_data_i) else $error("port 0 not on bus data");
   a_ext_p2_drive: assert property ((ext_bus_i && $stable(ext_p2_addr_i)) [*4] |->
      pull_down_o[23:16] == ~ext_p2_addr_i) else $error("port 2 not on bus address");
   a_rmw_read_latch: assert property ($past(rmw_rd) |-> sfr_rdata_o == latch_o[15:8])
      else $error("rmw read not latch");
   for (genvar b = 8; b < 40; b++) begin : g_bst
      a_boost_two_clk: assert property ($fell(pull_down_o[b]) && !ext_bus_i |->
         boost_pullup_o[b] [*2] ##1 !boost_pullup_o[b]) else $error("boost not two clocks");
   end
   c_rmw_write: cover property (sfr_req_i.wr && sfr_req_i.rmw);
   c_boost_seen: cover property (|boost_pullup_o);
   c_ext_bus: cover property (ext_bus_i);
endmodule
bind qbp_port_ctrl qbp_port_ctrl_checker u_chk (.clk_sys_i, .rst_i, .sfr_req_i, .ext_bus_i,
   .ext_p0_data_i, .ext_p2_addr_i, .pin_i, .sfr_rdata_o, .pull_down_o, .boost_pullup_o,
   .weak_hold_pullup_o, .very_weak_pullup_o, .latch_o);

// *** qbp_port_ctrl_tb.sv ***
// self-checking bench for the port control block
`timescale 1ns/10ps
module qbp_port_ctrl_tb;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, iend = 1'b0, istart = 1'b0, xbus = 1'b0;
   logic [7:0] p0d = 8'h00, p2a = 8'h00, rd, a, d;
   logic [39:0] pin, pd, bst, wh, vw, lat, xlow = 40'h0, exp_l = '1, old;
   logic [23:0] alt = '1;
   qbp_pkg::qbp_sfr_req_t req = '0;
   int n_fail = 0, n_tests = 0, p;
   always #4 clk_sys_i = ~clk_sys_i;
   qbp_port_ctrl DUT (.clk_sys_i, .rst_i, .sfr_req_i(req), .instr_end_i(iend),
      .instr_start_i(istart), .ext_bus_i(xbus), .ext_p0_data_i(p0d), .ext_p2_addr_i(p2a),
      .alt_out_p1_i(alt[7:0]), .alt_out_p3_i(alt[15:8]), .alt_out_p4_i(alt[23:16]), .pin_i(pin),
      .sfr_rdata_o(rd), .pull_down_o(pd), .boost_pullup_o(bst), .weak_hold_pullup_o(wh),
      .very_weak_pullup_o(vw), .latch_o(lat));
   qbp_pins_model PM (.clk_i(clk_sys_i), .pull_down_i(pd), .pullup_i(bst | wh | vw),
      .ext_low_i(xlow), .pin_o(pin));
   function automatic logic [7:0] adr(input int n);
      return 8'(8'h80 + 8'(n) * 8'h10);
   endfunction
   function automatic logic [39:0] rise(input logic [39:0] prev, input logic [39:0] cur);
      return cur & ~prev & ~40'hff;
   endfunction
   function automatic logic [7:0] drv(input logic [7:0] l, input logic [7:0] alt_b);
      return l & alt_b;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic r, input logic m, input logic [7:0] ad,
                      input logic [7:0] dt);
      @(negedge clk_sys_i) req = '{w, r, m, ad, dt};
      @(negedge clk_sys_i) req = '0;
   endtask
   task automatic finish_test;
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
   initial begin
      void'($urandom(99));
      cyc(2);
      rst_i = 1'b0;
      cyc(1);
      chk(lat, '1);
      for (int i = 0; i < 24; i++) begin
         p = (i < 3) ? 1 : int'($urandom % 5);
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         a = (i == 2) ? 8'h91 : adr(p);
         old = exp_l;
         acc(1'b1, 1'b0, 1'b0, a, d);
         if (i != 2) exp_l[p*8+:8] = d;
         for (int k = 0; k < 4; k++) begin
            cyc(1);
            chk(bst, (k == 1 || k == 2) ? rise(old, exp_l) : 40'h0);
         end
         chk(lat, exp_l);
         chk(pd, ~exp_l);
         chk(vw, {exp_l[39:8], 8'h00});
         chk(wh, {exp_l[39:8], 8'h00});
      end
      acc(1'b1, 1'b0, 1'b0, 8'h90, 8'hff);
      exp_l[15:8] = 8'hff;
      xlow = 40'h100;
      cyc(4);
      acc(1'b0, 1'b1, 1'b0, 8'h90, 8'h00);
      chk(rd, 8'hfe);
      acc(1'b0, 1'b1, 1'b1, 8'h90, 8'h00);
      chk(rd, 8'hff);
      d = exp_l[31:24] ^ 8'hff;
      acc(1'b1, 1'b0, 1'b1, 8'hb0, d);
      cyc(3);
      chk(lat[31:24], exp_l[31:24]);
      iend = 1'b1;
      cyc(1);
      iend = 1'b0;
      cyc(2);
      chk(lat[31:24], d);
      chk(pd[31:24], exp_l[31:24] ^ 8'hff);
      istart = 1'b1;
      cyc(1);
      istart = 1'b0;
      cyc(3);
      chk(pd[31:24], d ^ 8'hff);
      exp_l[31:24] = d;
      alt = 24'($urandom);
      cyc(2);
      chk(pd[15:8], drv(exp_l[15:8], alt[7:0]) ^ 8'hff);
      chk(pd[31:24], drv(exp_l[31:24], alt[15:8]) ^ 8'hff);
      chk(pd[39:32], drv(exp_l[39:32], alt[23:16]) ^ 8'hff);
      alt = '1;
      xbus = 1'b1;
      p0d = 8'($urandom);
      p2a = 8'($urandom);
      for (int k = 0; k < 3; k++) begin
         cyc(1);
         chk(bst[7:0], (k < 2) ? p0d & ~exp_l[7:0] : 8'h00);
         chk(bst[23:16], (k < 2) ? p2a & ~exp_l[23:16] : 8'h00);
      end
      cyc(1);
      chk(pd[7:0], p0d ^ 8'hff);
      chk(pd[23:16], p2a ^ 8'hff);
      xbus = 1'b0;
      rst_i = 1'b1;
      cyc(2);
      rst_i = 1'b0;
      cyc(1);
      chk(lat, '1);
      chk(pd, 40'h0);
      chk(bst, 40'h0);
      chk(rd, 8'h00);
      finish_test();
   end
endmodule
